// ==== hw/cssrq_top.sv ====
// Notes on behaviour
// - communication group uses 16-bit condition, filters, event, enable and one summary.
// - condition bit 15 is unused and always reads zero.
// - condition bit 1 is high while transmit analyzer channel has failed.
// - condition bit 0 is high while receive analyzer channel has failed.
// - both transition filters are writable and read back their pattern.
// - event register clears on each query of it and on clear-status.
// - enable register holds until rewritten; writing zero clears all bits.
// - six groups each reduce to one summary feeding the status byte.
// - status byte bit 7 carries the operation group summary.
// - bit 5 carries standard event summary; bit 4 flags output message available.
// - status byte bit 3 carries questionable data and signal summary.
// - bit 1 is hardware group two, bit 0 hardware group one, bit 2 unused.
// - bit 6 reads request-service on serial poll, master summary on byte query.
// - a status bit requests service only when its enable bit is set.
// - an enabled service condition drives the request line and sets request-service.
// - serial poll clears request-service until a new reason arises.
// - group summary true when enabled event bits set since last read or clear.
// - service request enable ignores written bit 6.
`timescale 1ns/100ps
`include "cssrq_params.svh"
module cssrq_top
  import cssrq_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_tx_fail,
  input  wire logic        i_rx_fail,
  input  wire cssrq_req_t  i_req,
  input  wire logic        i_serial_poll,
  input  wire cssrq_sum_t  i_sum,
  output logic [15:0]      o_rdata,
  output logic             o_rvalid,
  output logic [7:0]       o_poll_byte,
  output logic             o_poll_valid,
  output logic             o_srq,
  output logic             o_comm_summary
);
  logic [1:0]  fail_sync;
  logic [15:0] cond_w;
  logic [15:0] ptr_w;
  logic [15:0] ntr_w;
  logic [15:0] event_w;
  logic [15:0] enab_w;
  logic        comm_sum_w;
  logic [7:0]  sre_q;
  logic        rqs_q;
  logic        mss_q;
  logic [15:0] rdata_q;
  logic        rvalid_q;
  logic [7:0]  poll_q;
  logic        poll_valid_q;
  logic        comm_sum_q;

  // failure flags arrive from the analyzer side, outside this clock
  cssrq_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async ({i_tx_fail, i_rx_fail}),
    .o_sync  (fail_sync)
  );

  // only the two failure bits ever reach the condition register
  wire [15:0] cond_in = {14'h0000, fail_sync} & `CSSRQ_COND_USED_MASK;

  wire wr_ptr   = i_req.wr && (i_req.wcmd == CSSRQ_CMD_WR_PTR);
  wire wr_ntr   = i_req.wr && (i_req.wcmd == CSSRQ_CMD_WR_NTR);
  wire wr_enab  = i_req.wr && (i_req.wcmd == CSSRQ_CMD_WR_ENAB);
  wire wr_sre   = i_req.wr && (i_req.wcmd == CSSRQ_CMD_WR_SRE);
  wire rd_event = i_req.rd && (i_req.rsel == CSSRQ_RD_EVEN);
  wire ev_clear = rd_event || i_req.cls;

  cssrq_group #(
    .WIDTH (16)
  ) u_comm (
    .i_clock   (i_clock),
    .i_reset   (i_reset),
    .i_cond    (cond_in),
    .i_wr_ptr  (wr_ptr),
    .i_wr_ntr  (wr_ntr),
    .i_wr_enab (wr_enab),
    .i_wdata   (i_req.wdata),
    .i_clear   (ev_clear),
    .o_cond    (cond_w),
    .o_ptr     (ptr_w),
    .o_ntr     (ntr_w),
    .o_event   (event_w),
    .o_enab    (enab_w),
    .o_summary (comm_sum_w)
  );

  // status byte without bit 6; the communication summary is not part of it and only drives o_comm_summary
  wire [7:0] stb_base;
  assign stb_base[`CSSRQ_STB_OPER_BIT] = i_sum.oper;
  assign stb_base[`CSSRQ_STB_RQS_BIT]  = 1'b0;
  assign stb_base[`CSSRQ_STB_ESB_BIT]  = i_sum.esb;
  assign stb_base[`CSSRQ_STB_MAV_BIT]  = i_sum.mav;
  assign stb_base[`CSSRQ_STB_QUES_BIT] = i_sum.ques;
  assign stb_base[`CSSRQ_STB_UNUSED]   = 1'b0;
  assign stb_base[`CSSRQ_STB_HW2_BIT]  = i_sum.hw2;
  assign stb_base[`CSSRQ_STB_HW1_BIT]  = i_sum.hw1;

  wire       mss_d   = |(stb_base & sre_q);
  // request is only raised on a fresh reason, so a second poll reads it false
  wire       new_req = mss_d && !mss_q;
  wire       rqs_set = new_req;
  wire [7:0] stb_mss = stb_base | (8'(mss_q) << `CSSRQ_STB_RQS_BIT);
  wire [7:0] stb_rqs = stb_base | (8'(rqs_q) << `CSSRQ_STB_RQS_BIT);

  wire [15:0] rd_mux =
      (i_req.rsel == CSSRQ_RD_COND) ? cond_w :
      (i_req.rsel == CSSRQ_RD_PTR)  ? ptr_w :
      (i_req.rsel == CSSRQ_RD_NTR)  ? ntr_w :
      (i_req.rsel == CSSRQ_RD_EVEN) ? event_w :
      (i_req.rsel == CSSRQ_RD_ENAB) ? enab_w :
      (i_req.rsel == CSSRQ_RD_SRE)  ? {8'h00, sre_q} :
      (i_req.rsel == CSSRQ_RD_STB)  ? {8'h00, stb_mss} : 16'h0000;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sre_q <= `CSSRQ_SRE_RESET;
    end else if (wr_sre) begin
      sre_q <= i_req.wdata[7:0] & `CSSRQ_SRE_WR_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mss_q <= 1'b0;
      rqs_q <= 1'b0;
    end else begin
      mss_q <= mss_d;
      // a new reason beats a poll in the same cycle
      if (rqs_set) begin
        rqs_q <= 1'b1;
      end else if (i_serial_poll || !mss_q) begin
        rqs_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rdata_q      <= 16'h0000;
      rvalid_q     <= 1'b0;
      poll_q       <= 8'h00;
      poll_valid_q <= 1'b0;
      comm_sum_q   <= 1'b0;
    end else begin
      rvalid_q     <= i_req.rd;
      if (i_req.rd) begin
        rdata_q <= rd_mux;
      end
      poll_valid_q <= i_serial_poll;
      if (i_serial_poll) begin
        poll_q <= stb_rqs;
      end
      comm_sum_q <= comm_sum_w;
    end
  end

  // line tracks the request-service bit, so the poll drops it too
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_srq <= 1'b0;
    end else begin
      o_srq <= rqs_set || (rqs_q && !i_serial_poll && mss_q);
    end
  end

  assign o_rdata        = rdata_q;
  assign o_rvalid       = rvalid_q;
  assign o_poll_byte    = poll_q;
  assign o_poll_valid   = poll_valid_q;
  assign o_comm_summary = comm_sum_q;
endmodule

// ==== hw/cssrq_params.svh ====
`ifndef CSSRQ_PARAMS_SVH
`define CSSRQ_PARAMS_SVH

// communication group condition bit positions
`define CSSRQ_COND_RX_FAIL_BIT 0
`define CSSRQ_COND_TX_FAIL_BIT 1
`define CSSRQ_COND_USED_MASK   16'h0003

// status byte bit positions
`define CSSRQ_STB_HW1_BIT  0
`define CSSRQ_STB_HW2_BIT  1
`define CSSRQ_STB_UNUSED   2
`define CSSRQ_STB_QUES_BIT 3
`define CSSRQ_STB_MAV_BIT  4
`define CSSRQ_STB_ESB_BIT  5
`define CSSRQ_STB_RQS_BIT  6
`define CSSRQ_STB_OPER_BIT 7

// service request enable write mask, bit 6 ignored
`define CSSRQ_SRE_WR_MASK 8'hBF

// reset values
`define CSSRQ_PTR_RESET  16'hFFFF
`define CSSRQ_NTR_RESET  16'h0000
`define CSSRQ_ENAB_RESET 16'h0000
`define CSSRQ_SRE_RESET  8'h00

`endif

// ==== hw/cssrq_pkg.sv ====
package cssrq_pkg;

  typedef enum logic [2:0] {
    CSSRQ_CMD_NONE,
    CSSRQ_CMD_WR_PTR,
    CSSRQ_CMD_WR_NTR,
    CSSRQ_CMD_WR_ENAB,
    CSSRQ_CMD_WR_SRE
  } cssrq_wcmd_t;

  typedef enum logic [2:0] {
    CSSRQ_RD_COND,
    CSSRQ_RD_PTR,
    CSSRQ_RD_NTR,
    CSSRQ_RD_EVEN,
    CSSRQ_RD_ENAB,
    CSSRQ_RD_SRE,
    CSSRQ_RD_STB
  } cssrq_rsel_t;

  // one parsed command from the message layer
  typedef struct packed {
    logic        wr;
    cssrq_wcmd_t wcmd;
    logic [15:0] wdata;
    logic        rd;
    cssrq_rsel_t rsel;
    logic        cls;
  } cssrq_req_t;

  // summaries from the other status groups
  typedef struct packed {
    logic oper;
    logic esb;
    logic mav;
    logic ques;
    logic hw2;
    logic hw1;
  } cssrq_sum_t;

endpackage

// ==== hw/cssrq_sync.sv ====
`timescale 1ns/100ps
module cssrq_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ==== hw/cssrq_group.sv ====
`timescale 1ns/100ps
`include "cssrq_params.svh"
module cssrq_group
  import cssrq_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_cond,
  input  wire logic             i_wr_ptr,
  input  wire logic             i_wr_ntr,
  input  wire logic             i_wr_enab,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_clear,
  output logic      [WIDTH-1:0] o_cond,
  output logic      [WIDTH-1:0] o_ptr,
  output logic      [WIDTH-1:0] o_ntr,
  output logic      [WIDTH-1:0] o_event,
  output logic      [WIDTH-1:0] o_enab,
  output logic                  o_summary
);
  logic [WIDTH-1:0] cond_q;
  logic [WIDTH-1:0] ptr_q;
  logic [WIDTH-1:0] ntr_q;
  logic [WIDTH-1:0] event_q;
  logic [WIDTH-1:0] enab_q;
  logic             sum_q;

  wire [WIDTH-1:0] rise    = i_cond & ~cond_q;
  wire [WIDTH-1:0] fall    = ~i_cond & cond_q;
  wire [WIDTH-1:0] hits    = (rise & ptr_q) | (fall & ntr_q);
  // new hits win over a clear in the same cycle
  wire [WIDTH-1:0] event_d = (i_clear ? '0 : event_q) | hits;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cond_q  <= '0;
      ptr_q   <= `CSSRQ_PTR_RESET;
      ntr_q   <= `CSSRQ_NTR_RESET;
      event_q <= '0;
      enab_q  <= `CSSRQ_ENAB_RESET;
      sum_q   <= 1'b0;
    end else begin
      cond_q  <= i_cond;
      event_q <= event_d;
      if (i_wr_ptr) begin
        ptr_q <= i_wdata;
      end
      if (i_wr_ntr) begin
        ntr_q <= i_wdata;
      end
      if (i_wr_enab) begin
        enab_q <= i_wdata;
      end
      sum_q <= |(event_q & enab_q);
    end
  end

  assign o_cond    = cond_q;
  assign o_ptr     = ptr_q;
  assign o_ntr     = ntr_q;
  assign o_event   = event_q;
  assign o_enab    = enab_q;
  assign o_summary = sum_q;
endmodule

// ==== dv/cssrq_ctrl.sv ====
`timescale 1ns/100ps
module cssrq_ctrl
  import cssrq_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  input  wire logic [7:0]  i_poll_byte,
  input  wire logic        i_poll_valid,
  output cssrq_req_t       o_req,
  output logic             o_serial_poll
);
  initial begin
    o_req = '0;
    o_serial_poll = 1'b0;
  end
  // one-cycle command, then idle for a cycle
  task automatic send(input cssrq_req_t r);
    @(posedge i_clock);
    o_req <= r;
    @(posedge i_clock);
    o_req <= '0;
  endtask
  task automatic wr(input cssrq_wcmd_t c, input logic [15:0] v);
    send('{1'b1, c, v, 1'b0, CSSRQ_RD_COND, 1'b0});
  endtask
  task automatic cls;
    send('{1'b0, CSSRQ_CMD_NONE, 16'h0000, 1'b0, CSSRQ_RD_COND, 1'b1});
  endtask
  // no answer yields unknown so a missing pulse never matches
  task automatic rd(input cssrq_rsel_t s, output logic [15:0] v);
    send('{1'b0, CSSRQ_CMD_NONE, 16'h0000, 1'b1, s, 1'b0});
    #1 v = i_rvalid ? i_rdata : 'x;
  endtask
  task automatic poll(output logic [7:0] v);
    @(posedge i_clock);
    o_serial_poll <= 1'b1;
    @(posedge i_clock);
    o_serial_poll <= 1'b0;
    #1 v = i_poll_valid ? i_poll_byte : 'x;
  endtask
endmodule

// ==== dv/cssrq_assertions.sv ====
`timescale 1ns/100ps
module cssrq_chk
  import cssrq_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire cssrq_req_t  i_req,
  input wire logic        i_serial_poll,
  input wire logic [15:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic [7:0]  o_poll_byte,
  input wire logic        o_poll_valid,
  input wire logic        o_srq
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  a_read_answered: assert property (i_req.rd |=> o_rvalid)
    else $error("read got no answer");
  a_answer_caused: assert property (o_rvalid |-> $past(i_req.rd))
    else $error("answer without read");
  a_poll_answered: assert property (i_serial_poll |=> o_poll_valid)
    else $error("poll got no byte");
  a_poll_clears: assert property (i_serial_poll && o_srq |=> !o_srq)
    else $error("request kept after poll");
  a_poll_rqs: assert property (o_poll_valid |-> o_poll_byte[6] == $past(o_srq))
    else $error("poll bit 6 not request state");
  a_stb_unused: assert property (o_poll_valid |-> !o_poll_byte[2])
    else $error("status bit 2 set");
  a_cond_unused: assert property (o_rvalid && $past(i_req.rsel) == CSSRQ_RD_COND
    |-> o_rdata[15:2] == 14'h0000) else $error("unused condition bit set");
  a_sre_masked: assert property (o_rvalid && $past(i_req.rsel) == CSSRQ_RD_SRE
    |-> o_rdata[15:8] == 8'h00 && !o_rdata[6]) else $error("enable bit 6 kept");
endmodule
bind cssrq_top cssrq_chk u_chk (.i_clock(i_clock), .i_reset(i_reset), .i_req(i_req),
  .i_serial_poll(i_serial_poll), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_poll_byte(o_poll_byte), .o_poll_valid(o_poll_valid), .o_srq(o_srq));

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
  import cssrq_pkg::*;
;
  logic        clk, rst, tx, rx, sp, rv, pv, srq, cs;
  logic [15:0] rdat, d;
  logic [7:0]  pb, b;
  cssrq_req_t  req;
  cssrq_sum_t  sum;
  int          mismatches, n_tests;
  localparam cssrq_rsel_t CO = CSSRQ_RD_COND;
  localparam cssrq_rsel_t EV = CSSRQ_RD_EVEN;

  cssrq_top DUT (.i_clock(clk), .i_reset(rst), .i_tx_fail(tx), .i_rx_fail(rx),
    .i_req(req), .i_serial_poll(sp), .i_sum(sum), .o_rdata(rdat), .o_rvalid(rv),
    .o_poll_byte(pb), .o_poll_valid(pv), .o_srq(srq), .o_comm_summary(cs));
  cssrq_ctrl ctl (.i_clock(clk), .i_rdata(rdat), .i_rvalid(rv), .i_poll_byte(pb),
    .i_poll_valid(pv), .o_req(req), .o_serial_poll(sp));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task rq(input cssrq_rsel_t s, input logic [15:0] e);
    ctl.rd(s, d);
    chk(s.name(), e, d);
  endtask
  // land one ns past the edge so outputs have settled
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task t_regs;
    rq(CSSRQ_RD_PTR, 16'hFFFF);
    rq(CSSRQ_RD_ENAB, 16'h0000);
    ctl.wr(CSSRQ_CMD_WR_PTR, 16'h5A5A);
    ctl.wr(CSSRQ_CMD_WR_NTR, 16'hA5A5);
    ctl.wr(CSSRQ_CMD_WR_SRE, 16'hFFFF);
    rq(CSSRQ_RD_PTR, 16'h5A5A);
    rq(CSSRQ_RD_NTR, 16'hA5A5);
    rq(CSSRQ_RD_SRE, 16'h00BF);
    ctl.wr(CSSRQ_CMD_WR_PTR, 16'hFFFF);
    ctl.wr(CSSRQ_CMD_WR_SRE, 16'h0000);
    $display("t_regs done");
  endtask

  task t_events;
    ctl.wr(CSSRQ_CMD_WR_ENAB, 16'h0003);
    ctl.wr(CSSRQ_CMD_WR_NTR, 16'h0002);
    rx <= 1'b1;
    w(8);
    rq(CO, 16'h0001);
    chk("summary", 16'h0001, {15'h0000, cs});
    rq(EV, 16'h0001);
    rq(EV, 16'h0000);
    w(3);
    chk("summary", 16'h0000, {15'h0000, cs});
    tx <= 1'b1;
    w(8);
    rq(CO, 16'h0003);
    rq(EV, 16'h0002);
    tx <= 1'b0;
    w(8);
    rq(EV, 16'h0002);
    rx <= 1'b0;
    w(8);
    rq(EV, 16'h0000);
    tx <= 1'b1;
    w(8);
    ctl.cls;
    rq(EV, 16'h0000);
    tx <= 1'b0;
    w(8);
    chk("summary", 16'h0001, {15'h0000, cs});
    ctl.wr(CSSRQ_CMD_WR_ENAB, 16'h0000);
    w(3);
    chk("summary", 16'h0000, {15'h0000, cs});
    rq(EV, 16'h0002);
    $display("t_events done");
  endtask

  task t_srq;
    ctl.wr(CSSRQ_CMD_WR_SRE, 16'h0001);
    sum <= 6'h01;
    w(6);
    chk("srq", 16'h0001, {15'h0000, srq});
    ctl.poll(b);
    chk("poll", 16'h0041, {8'h00, b});
    chk("srq", 16'h0000, {15'h0000, srq});
    ctl.poll(b);
    chk("poll", 16'h0001, {8'h00, b});
    rq(CSSRQ_RD_STB, 16'h0041);
    // let the master summary fall first so an ungated bit would make a fresh request
    sum <= 6'h00;
    w(3);
    sum <= 6'h3E;
    w(6);
    chk("srq", 16'h0000, {15'h0000, srq});
    rq(CSSRQ_RD_STB, 16'h00BA);
    $display("t_srq done");
  endtask

  initial begin
    mismatches = 0;
    n_tests = 0;
    rst = 1'b1;
    tx = 1'b0;
    rx = 1'b0;
    sum = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_events;
    t_srq;
    end_of_test;
  end

  initial begin
    #100000;
    mismatches++;
    end_of_test;
  end
endmodule
